// ### hdl/usc_serial_channel.sv
// Serial control channel: APB registers, transmitter, receiver and mode 0 shifter
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Invalid stop bit sets framing error flag
// - Framing flag stays until software clears it
// - Bit 7 maps framing flag or mode bit
// - Mode bits pick shift or UART format
// - Multiprocessor enable filters frames in modes 1-3
// - Reception only while receive enable set, except a mode 0 byte already in progress
// - Modes 2,3 send tx ninth bit
// - Modes 2,3 store received ninth bit
// - Mode 1 stores stop bit in ninth field
// - Tx done: mode 0 eighth bit, else stop
// - Mode 0 rx done after eighth bit
// - Control register resets zero, bit-writable
// - Generator clocks modes 1,3, and mode 0 optionally
// - Access select routes bit 7 to framing flag
// - Doubler doubles rate in modes 1-3
// - Generator divides by 2, 6, 256-reload
module usc_serial_channel
  import usc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        rxdIn,
  output logic             rxdOut,
  output logic             rxdOe,
  output logic             txdOut
);

  // ==========================================================================
  // Registers and state
  // ==========================================================================
  logic [7:0]          scon;       // Control register image, bit 7 is mode bit 0
  logic                feFlag;     // framing_error_flag
  logic [CF_WIDTH-1:0] cfg;        // Clocking configuration
  logic [7:0]          reload;     // generator_reload_value
  logic [7:0]          rxData;     // Last accepted byte
  usc_tx_state_t       txState;
  usc_rx_state_t       rxState;
  logic [3:0]          txCnt, rxCnt; // Sample counters within a bit
  logic [3:0]          txBit, rxBit; // Bit index within a frame
  logic [8:0]          txShift, rxShift;
  logic                txLine;     // Async transmit level
  logic                shiftClk;   // Mode 0 shift clock, idles high
  logic                sampPhase;  // Halves the sample base unless doubled
  logic                rxdPrev;    // Previous line level for start detection

  // Next values
  logic [7:0]    next_scon;
  logic          next_fe;
  usc_tx_state_t next_txState;
  usc_rx_state_t next_rxState;
  logic [3:0]    next_txCnt, next_rxCnt, next_txBit, next_rxBit;
  logic [8:0]    next_txShift, next_rxShift;
  logic          next_txLine;
  logic [7:0]    next_rxData;
  logic          txDoneSet, rxDoneSet, feSet, rx9Load, rx9Val;

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == ADDR_SCON) | (a == ADDR_CFG) | (a == ADDR_RELOAD) |
               (a == ADDR_TXDATA) | (a == ADDR_RXDATA) | (a == ADDR_BITWR);
  endfunction

  wire logic writeEdge = psel & penable & pwrite;   // Write lands at access edge
  wire logic setupRead = psel & ~penable;           // Read data captured in setup
  wire logic wrScon    = writeEdge & (paddr == ADDR_SCON);
  wire logic wrCfg     = writeEdge & (paddr == ADDR_CFG);
  wire logic wrReload  = writeEdge & (paddr == ADDR_RELOAD);
  wire logic wrTx      = writeEdge & (paddr == ADDR_TXDATA);
  wire logic wrBit     = writeEdge & (paddr == ADDR_BITWR);
  wire logic [2:0] bitIdx = pwdata[2:0];
  wire logic fas       = cfg[CF_FAS];

  // Bit 7 view depends on the access select
  wire logic [7:0] sconView = {fas ? feFlag : scon[SC_MODE0], scon[6:0]};

  // Zero wait states: answer in the first access cycle
  assign pready = 1'b1;

  // ==========================================================================
  // Mode and clock selection
  // ==========================================================================
  wire usc_mode_t mode   = usc_mode_t'({scon[SC_MODE0], scon[SC_MODE1]});
  wire logic isMode0     = (mode == MODE_SHIFT);
  wire logic isNine      = (mode == MODE_FIX9) | (mode == MODE_VAR9);
  wire logic mpActive    = scon[SC_MPE] & ~isMode0;
  wire logic ren         = scon[SC_REN];
  wire logic perTick, div6Tick, brgOvf;

  usc_baud_gen u_baud
  (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .doubleSpeed  (cfg[CF_X2]),
    .speedSelect  (cfg[CF_SPD]),
    .generatorRun (cfg[CF_RUN]),
    .reloadValue  (reload),
    .perTick      (perTick),
    .div6Tick     (div6Tick),
    .brgOverflow  (brgOvf)
  );

  // Mode 2 runs off the peripheral clock, modes 1 and 3 off the generator
  wire logic sampleBase = (mode == MODE_FIX9) ? perTick : brgOvf;
  // Sixteen samples per bit; the doubler drops the extra halving
  wire logic sampleTick = sampleBase & (cfg[CF_DOUBLER] | sampPhase);
  // Mode 0 bit time: peripheral clock /6 or the generator
  wire logic mode0Tick  = cfg[CF_SRC] ? brgOvf : div6Tick;
  // Move on only once the far side has seen the clock rise, or a bit is lost
  wire logic m0Step     = mode0Tick & shiftClk;

  wire logic tx0Busy  = isMode0 & (txState == TX_DATA);
  wire logic rx0Busy  = isMode0 & (rxState == RX_DATA);
  wire logic txStart  = wrTx & (txState == TX_IDLE) & ~rx0Busy;
  wire logic rx0Start = isMode0 & ren & ~scon[SC_RX_DONE] & (rxState == RX_IDLE) &
                        (txState == TX_IDLE) & ~txStart;
  wire logic [3:0] bit0Now = tx0Busy ? txBit : rxBit;
  wire logic mode0Sample = rx0Busy & perTick & ~shiftClk;
  wire logic rxLastBit   = (rxBit == (isNine ? BIT9_LAST : BIT8_LAST));

  // ==========================================================================
  // Transmitter
  // ==========================================================================
  // Frame sequencing; the ninth bit is the stored tx ninth bit
  always_comb
  begin
    next_txState = txState;
    next_txCnt   = txCnt;
    next_txBit   = txBit;
    next_txShift = txShift;
    next_txLine  = txLine;
    txDoneSet    = 1'b0;
    unique case (txState)
      TX_IDLE:
        if (txStart)
        begin
          next_txShift = {scon[SC_TX9], pwdata[7:0]};
          next_txBit   = 4'h0;
          next_txCnt   = 4'h0;
          next_txState = isMode0 ? TX_DATA : TX_START;
          next_txLine  = isMode0;
        end
      TX_START:
        if (sampleTick)
        begin
          next_txCnt = txCnt + 4'h1;
          if (txCnt == SAMPLE_LAST)
          begin
            next_txState = TX_DATA;
            next_txLine  = txShift[0];
          end
        end
      TX_DATA:
        if (isMode0)
        begin
          // One bit per mode 0 tick, done after the eighth
          if (m0Step)
          begin
            next_txShift = {1'b0, txShift[8:1]};
            next_txBit   = txBit + 4'h1;
            if (txBit == BIT8_LAST)
            begin
              txDoneSet    = 1'b1;
              next_txState = TX_IDLE;
            end
          end
        end
        else if (sampleTick)
        begin
          next_txCnt = txCnt + 4'h1;
          if (txCnt == SAMPLE_LAST)
          begin
            next_txShift = {1'b0, txShift[8:1]};
            next_txBit   = txBit + 4'h1;
            next_txLine  = txShift[1];
            if (txBit == BIT8_LAST && isNine)
              next_txState = TX_NINTH;
            else if (txBit == BIT8_LAST)
            begin
              next_txState = TX_STOP;
              next_txLine  = 1'b1;
              txDoneSet    = 1'b1;
            end
          end
        end
      TX_NINTH:
        if (sampleTick)
        begin
          next_txCnt = txCnt + 4'h1;
          if (txCnt == SAMPLE_LAST)
          begin
            next_txState = TX_STOP;
            next_txLine  = 1'b1;
            txDoneSet    = 1'b1;
          end
        end
      TX_STOP:
        if (sampleTick)
        begin
          next_txCnt = txCnt + 4'h1;
          if (txCnt == SAMPLE_LAST)
            next_txState = TX_IDLE;
        end
      default:
        next_txState = TX_IDLE;
    endcase
  end

  // ==========================================================================
  // Receiver
  // ==========================================================================
  // Async frames sample mid-bit; mode 0 samples on the shift clock rise
  always_comb
  begin
    next_rxState = rxState;
    next_rxCnt   = rxCnt;
    next_rxBit   = rxBit;
    next_rxShift = mode0Sample ? {rxdIn, rxShift[8:1]} : rxShift;
    next_rxData  = rxData;
    rxDoneSet    = 1'b0;
    feSet        = 1'b0;
    rx9Load      = 1'b0;
    rx9Val       = 1'b0;
    if (!ren && !rx0Busy)
      next_rxState = RX_IDLE;
    else
      unique case (rxState)
        RX_IDLE:
          if (rx0Start)
          begin
            next_rxState = RX_DATA;
            next_rxBit   = 4'h0;
          end
          else if (!isMode0 && rxdPrev && !rxdIn)
          begin
            next_rxState = RX_START;
            next_rxCnt   = 4'h0;
          end
        RX_START:
          if (sampleTick)
          begin
            next_rxCnt = rxCnt + 4'h1;
            // A start bit that is high at mid-bit was a glitch
            if (rxCnt == SAMPLE_MID && rxdIn)
              next_rxState = RX_IDLE;
            else if (rxCnt == SAMPLE_LAST)
            begin
              next_rxState = RX_DATA;
              next_rxBit   = 4'h0;
            end
          end
        RX_DATA:
          if (isMode0)
          begin
            if (m0Step)
            begin
              next_rxBit = rxBit + 4'h1;
              if (rxBit == BIT8_LAST)
              begin
                next_rxState = RX_IDLE;
                next_rxData  = next_rxShift[8:1];
                rxDoneSet    = 1'b1;
              end
            end
          end
          else if (sampleTick)
          begin
            next_rxCnt = rxCnt + 4'h1;
            if (rxCnt == SAMPLE_MID)
              next_rxShift = {rxdIn, rxShift[8:1]};
            if (rxCnt == SAMPLE_LAST)
            begin
              next_rxBit = rxBit + 4'h1;
              if (rxLastBit)
                next_rxState = RX_STOP;
            end
          end
        RX_STOP:
          if (sampleTick)
          begin
            next_rxCnt = rxCnt + 4'h1;
            // Single stop check per frame, then back to hunting
            if (rxCnt == SAMPLE_MID)
            begin
              next_rxState = RX_IDLE;
              feSet        = ~rxdIn;
              rx9Val       = isNine ? rxShift[8] : rxdIn;
              // An unread byte blocks the next; filtering needs a set ninth bit
              if (!scon[SC_RX_DONE] && (!mpActive || rx9Val))
              begin
                rxDoneSet   = 1'b1;
                rx9Load     = 1'b1;
                next_rxData = isNine ? rxShift[7:0] : rxShift[8:1];
              end
            end
          end
        default:
          next_rxState = RX_IDLE;
      endcase
  end

  // ==========================================================================
  // Control register update
  // ==========================================================================
  // Hardware sets are applied last so they win over a same-cycle clear
  always_comb
  begin
    next_scon = scon;
    next_fe   = feFlag;
    if (wrScon)
    begin
      next_scon[6:0] = pwdata[6:0];
      if (fas)
        next_fe = pwdata[SC_MODE0];
      else
        next_scon[SC_MODE0] = pwdata[SC_MODE0];
    end
    if (wrBit)
    begin
      if (bitIdx == 3'(SC_MODE0) && fas)
        next_fe = pwdata[BW_VALUE];
      else
        next_scon[bitIdx] = pwdata[BW_VALUE];
    end
    if (rx9Load)
      next_scon[SC_RX9] = rx9Val;
    if (txDoneSet)
      next_scon[SC_TX_DONE] = 1'b1;
    if (rxDoneSet)
      next_scon[SC_RX_DONE] = 1'b1;
    if (feSet)
      next_fe = 1'b1;
  end

  // ==========================================================================
  // Flip-flops
  // ==========================================================================
  // Software-visible registers
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scon   <= SCON_RESET;
      feFlag <= 1'b0;
      cfg    <= CFG_RESET;
      reload <= RELOAD_RESET;
      rxData <= 8'h00;
    end
    else
    begin
      scon   <= next_scon;
      feFlag <= next_fe;
      cfg    <= wrCfg ? pwdata[CF_WIDTH-1:0] : cfg;
      reload <= wrReload ? pwdata[7:0] : reload;
      rxData <= next_rxData;
    end
  end

  // Frame state
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txState <= TX_IDLE;
      rxState <= RX_IDLE;
      txCnt   <= 4'h0;
      rxCnt   <= 4'h0;
      txBit   <= 4'h0;
      rxBit   <= 4'h0;
      txShift <= 9'h000;
      rxShift <= 9'h000;
      txLine  <= 1'b1;
    end
    else
    begin
      txState <= next_txState;
      rxState <= next_rxState;
      txCnt   <= next_txCnt;
      rxCnt   <= next_rxCnt;
      txBit   <= next_txBit;
      rxBit   <= next_rxBit;
      txShift <= next_txShift;
      rxShift <= next_rxShift;
      txLine  <= next_txLine;
    end
  end

  // Shift clock falls at each mode 0 bit start, rises on the next peripheral tick
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      shiftClk <= 1'b1;
    else if ((txStart && isMode0) || rx0Start ||
             ((tx0Busy || rx0Busy) && m0Step && bit0Now != BIT8_LAST))
      shiftClk <= 1'b0;
    else if (perTick)
      shiftClk <= 1'b1;
  end

  // Sample phase and line history
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sampPhase <= 1'b0;
      rxdPrev   <= 1'b1;
    end
    else
    begin
      sampPhase <= sampleBase ? ~sampPhase : sampPhase;
      rxdPrev   <= rxdIn;
    end
  end

  // APB read data and error captured in the setup cycle
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setupRead)
    begin
      pslverr <= ~isMapped(paddr);
      prdata  <= (paddr == ADDR_SCON)   ? {24'h00_0000, sconView} :
                 (paddr == ADDR_CFG)    ? {26'h000_0000, cfg} :
                 (paddr == ADDR_RELOAD) ? {24'h00_0000, reload} :
                 (paddr == ADDR_RXDATA) ? {24'h00_0000, rxData} : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Pins
  // ==========================================================================
  // In mode 0 the data pin carries the shifter and the transmit pin the clock
  assign rxdOe  = tx0Busy;
  assign rxdOut = txShift[0];
  assign txdOut = isMode0 ? shiftClk : txLine;

endmodule
`default_nettype wire

// ### hdl/usc_pkg.sv
// Shared constants, register map and state encodings of the serial control channel
package usc_pkg;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [7:0] ADDR_SCON   = 8'hC0; // Serial control register
  localparam logic [7:0] ADDR_CFG    = 8'hC4; // Clocking and access configuration
  localparam logic [7:0] ADDR_RELOAD = 8'hC8; // Baud generator reload value
  localparam logic [7:0] ADDR_TXDATA = 8'hCC; // Write starts a frame
  localparam logic [7:0] ADDR_RXDATA = 8'hD0; // Last accepted byte
  localparam logic [7:0] ADDR_BITWR  = 8'hD4; // Single-bit write into control register

  // ==========================================================================
  // Control register field positions
  // ==========================================================================
  localparam int SC_RX_DONE = 0; // rx_done_flag
  localparam int SC_TX_DONE = 1; // tx_done_flag
  localparam int SC_RX9     = 2; // rx_ninth_bit
  localparam int SC_TX9     = 3; // tx_ninth_bit
  localparam int SC_REN     = 4; // Receive enable
  localparam int SC_MPE     = 5; // multiprocessor_enable
  localparam int SC_MODE1   = 6; // mode_select_bit1
  localparam int SC_MODE0   = 7; // mode_select_bit0 or framing_error_flag

  // ==========================================================================
  // Configuration register field positions
  // ==========================================================================
  localparam int CF_FAS     = 0; // framing_access_select
  localparam int CF_DOUBLER = 1; // baud_doubler
  localparam int CF_SRC     = 2; // mode0_clock_source_select
  localparam int CF_SPD     = 3; // generator_speed_select
  localparam int CF_X2      = 4; // double_speed_clocking
  localparam int CF_RUN     = 5; // Baud generator run
  localparam int CF_WIDTH   = 6;

  // Single-bit write layout: index in [2:0], value in [3]
  localparam int BW_VALUE = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]          SCON_RESET   = 8'h00;
  localparam logic [CF_WIDTH-1:0] CFG_RESET    = 6'h00;
  localparam logic [7:0]          RELOAD_RESET = 8'h00;

  // ==========================================================================
  // Timing counts
  // ==========================================================================
  localparam logic [2:0] PRESCALE_LAST = 3'h5; // Divide by 6
  localparam logic [7:0] BRG_TOP       = 8'hFF; // Overflow point of the generator
  localparam logic [3:0] SAMPLE_MID    = 4'h7; // Mid-bit sample of 16
  localparam logic [3:0] SAMPLE_LAST   = 4'hF; // Last sample of a bit
  localparam logic [3:0] BIT8_LAST     = 4'h7; // Eighth data bit index
  localparam logic [3:0] BIT9_LAST     = 4'h8; // Ninth data bit index

  // ==========================================================================
  // Modes and states
  // ==========================================================================
  typedef enum logic [1:0]
  {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_FIX9  = 2'b10,
    MODE_VAR9  = 2'b11
  } usc_mode_t;

  typedef enum logic [2:0]
  {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b011,
    TX_NINTH = 3'b010,
    TX_STOP  = 3'b110
  } usc_tx_state_t;

  typedef enum logic [1:0]
  {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } usc_rx_state_t;

endpackage

// ### hdl/usc_baud_gen.sv
// Peripheral clock prescaler and dedicated internal baud rate generator
`timescale 1ns/1ps
`default_nettype none

module usc_baud_gen
  import usc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Configuration
  input  wire logic       doubleSpeed,
  input  wire logic       speedSelect,
  input  wire logic       generatorRun,
  input  wire logic [7:0] reloadValue,
  // Strobes
  output logic            perTick,
  output logic            div6Tick,
  output logic            brgOverflow
);

  // ==========================================================================
  // Peripheral clock
  // ==========================================================================
  logic       halfPhase;  // Alternates to halve the clock
  logic [2:0] preCount;   // Divide-by-6 prescaler
  logic [7:0] brgCount;   // Up counter, reloads on overflow
  wire  logic brgEnable;

  // Without double speed the peripheral rate is half the system clock
  assign perTick = doubleSpeed | halfPhase;
  assign div6Tick = perTick & (preCount == PRESCALE_LAST);
  // Speed bit skips the divide by 6
  assign brgEnable = generatorRun & (speedSelect ? perTick : div6Tick);
  assign brgOverflow = brgEnable & (brgCount == BRG_TOP);

  // ==========================================================================
  // Counters
  // ==========================================================================
  // Half-rate phase toggle
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      halfPhase <= 1'b0;
    else
      halfPhase <= ~halfPhase;
  end

  // Prescaler
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      preCount <= 3'h0;
    else if (div6Tick)
      preCount <= 3'h0;
    else if (perTick)
      preCount <= preCount + 3'h1;
  end

  // Generator: 256 minus reload steps between overflows
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      brgCount <= 8'h00;
    else if (brgOverflow)
      brgCount <= reloadValue;
    else if (brgEnable)
      brgCount <= brgCount + 8'h01;
  end

endmodule
`default_nettype wire

// ### tb/usc_serial_channel_monitor.sv
// Port checker for the serial control channel
`timescale 1ns/1ps
`default_nettype none
module usc_serial_channel_monitor
  import usc_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        rxdOe,
  input wire logic        txdOut
);
  // ======
  // Decode
  wire logic acc = psel && penable; // Access phase
  wire logic hit = paddr inside {ADDR_SCON, ADDR_CFG, ADDR_RELOAD, ADDR_TXDATA,
                                 ADDR_RXDATA, ADDR_BITWR}; // Mapped word
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ======
  // Checks
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !hit |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && hit |-> !pslverr) else $error("mapped refused");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_data_hold: assert property (acc |=> $stable(prdata) && $stable(pslverr))
    else $error("read data moved");
  a_oe_cause: assert property ($rose(rxdOe) |-> $past(acc && pwrite && paddr == ADDR_TXDATA))
    else $error("drive without write");
  a_oe_clock: assert property ($rose(rxdOe) |-> !txdOut) else $error("shift clock high");
  a_err_write: assert property (acc && pwrite && !hit |-> pslverr) else $error("bad write");
  c_read_ctl: cover property (acc && !pwrite && paddr == ADDR_SCON);
  c_start: cover property ($fell(txdOut));
  c_unmapped: cover property (acc && !hit);
endmodule
bind usc_serial_channel usc_serial_channel_monitor u_mon (.clock(clock), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxdOe(rxdOe), .txdOut(txdOut));
`default_nettype wire

// ### tb/usc_echo_partner.sv
// Far serial device: echoes each frame it hears, 16 clocks a bit
`timescale 1ns/1ps
`default_nettype none
module usc_echo_partner
(
  // Clock and controls
  input wire logic clock,
  input wire logic badStop,
  // Line
  input wire logic txd,
  output logic     rxd
);
  logic [9:0] bits; // Data, ninth, stop
  // Line idles high like a pulled-up wire
  initial
  begin
    rxd = 1'b1;
    forever
    begin
      @(negedge txd);
      repeat (8) @(posedge clock);
      for (int i = 0; i < 10; i++)
      begin
        repeat (16) @(posedge clock);
        bits[i] = txd;
      end
      bits[9] = !badStop; // Breaks the stop bit only on request
      rxd <= 1'b0;
      repeat (16) @(posedge clock);
      for (int i = 0; i < 10; i++)
      begin
        rxd <= bits[i];
        repeat (16) @(posedge clock);
      end
      rxd <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_usc_serial_channel.sv
// Bench for the serial control channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failCount++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_usc_serial_channel
  import usc_pkg::*;
;
  logic        clock, sys_rst, psel, penable, pwrite, badStop; // Drives
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic        pready, pslverr, rxdIn, rxdOut, rxdOe, txdOut;
  logic [32:0] notes[$]; // Expected {error, data}
  logic [32:0] want;     // Oldest note, taken once per read
  logic [7:0]  shiftSeen; // Mode 0 bits as the far side clocks them in
  int          failCount, checks;
  usc_serial_channel u_usc_serial_channel (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe),
    .txdOut(txdOut));
  usc_echo_partner u_usc_echo_partner (.clock(clock), .badStop(badStop), .txd(txdOut),
    .rxd(rxdIn));
  // ======
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Master holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) notes.push_back(e);
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // One frame out, its echo back: 11 bits each way at 16 clocks
  task automatic send();
    rnd = lfsr(rnd);
    apb(1'b1, ADDR_TXDATA, {24'h0, rnd[7:0]}, 33'h0);
    repeat (2 * 11 * 16 + 40) @(posedge clock);
  endtask
  task automatic endOfTest();
    $display("checks %0d failCount %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ======
  // Watcher: oldest note against each completed read
  always @(posedge clock)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      want = notes.pop_front();
      `CHK("read", want, {pslverr, prdata})
    end
  end
  // Mode 0 data is settled at each rise of the shift clock
  always @(posedge txdOut)
    if (rxdOe) shiftSeen <= {rxdOut, shiftSeen[7:1]};
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    repeat (6000) @(posedge clock);
    failCount++;
    endOfTest();
  end
  // ======
  // Main sequence
  initial
  begin
    {sys_rst, psel, penable, pwrite, badStop, paddr, pwdata} = {5'b10000, 8'h00, 32'h0};
    rnd = 32'hD3B552CB;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, ADDR_SCON, 32'h0, 33'h0);
    apb(1'b0, 8'hFC, 32'h0, {1'b1, 32'h0});
    apb(1'b1, ADDR_CFG, 32'h12, 33'h0);
    apb(1'b1, ADDR_SCON, 32'h88, 33'h0);
    send();
    apb(1'b0, ADDR_SCON, 32'h0, 33'h8A);
    apb(1'b1, ADDR_SCON, 32'h98, 33'h0);
    send();
    apb(1'b0, ADDR_SCON, 32'h0, 33'h9F);
    apb(1'b0, ADDR_RXDATA, 32'h0, {25'h0, rnd[7:0]});
    apb(1'b1, ADDR_SCON, 32'h90, 33'h0);
    apb(1'b1, ADDR_CFG, 32'h13, 33'h0);
    badStop <= 1'b1;
    send();
    apb(1'b0, ADDR_SCON, 32'h0, 33'h93);
    badStop <= 1'b0;
    apb(1'b1, ADDR_BITWR, 32'h00, 33'h0);
    send();
    apb(1'b0, ADDR_SCON, 32'h0, 33'h93);
    apb(1'b1, ADDR_BITWR, 32'h07, 33'h0);
    apb(1'b0, ADDR_SCON, 32'h0, 33'h13);
    apb(1'b1, ADDR_CFG, 32'h12, 33'h0);
    apb(1'b0, ADDR_SCON, 32'h0, 33'h93);
    apb(1'b1, ADDR_SCON, 32'hB0, 33'h0);
    send();
    apb(1'b0, ADDR_SCON, 32'h0, 33'hB2);
    apb(1'b1, ADDR_SCON, 32'h00, 33'h0);
    send();
    `CHK("shift", rnd[7:0], shiftSeen)
    apb(1'b0, ADDR_SCON, 32'h0, 33'h02);
    endOfTest();
  end
endmodule
`default_nettype wire
